/* hw/apm_alarm_manager.sv */
// Purpose: alarm handling, display scrolling and protections-disabled override
// Assumes: all inputs synchronous to sys_clk_in; mute_in is a one-cycle press
// Notes:   local sources occupy indices 0..N_LOCAL-1, internal ones follow
//
// How it works
// (R1) any active alarm drives sounder, and common LED when enabled
// (R2) mute press silences the sounder
// (R3) a newly active alarm switches display to the alarm page
// (R4) active alarms scroll automatically in the order they were raised
// (R5) a shutdown after a warning joins the list beside the warning
// (R6) override stops shutdowns and trips stopping the engine; status shown
// (R7) override is off, always on, or on while external switch is on
// (R8) operating the override switch may raise a warning, per configuration
// (R9) indication and warning handling ignore the override
// (R10) emergency stop always stops the engine, override or not
// (R11) overridden shutdown is displayed; engine runs, load switch stays put
// (R12) overridden shutdown also shows a shutdown-blocked flag
// (R13) logged shutdowns carry a note when the shutdown was prevented
// (R14) no engine link data in CAN mode raises data-fail shutdown
// (R15) controller warning shows its code and applies lamp message actions
// (R16) controller shutdown raises controller-shutdown alarm and shows code
// (R17) each lamp class maps to warning, trip, shutdown or none
// (R18) water-in-fuel and after-treatment take their configured action
// (R19) indication inputs raise no alarm and only drive their LED
// (R20) warnings self-clear unless latched, then need manual reset
// (R21) mute touches only the sounder; alarms stay until cleared
`timescale 1ns/100ps
module apm_alarm_manager
	import apm_pkg::*;
#(
	parameter int          N_LOCAL       = 8,
	parameter int unsigned DWELL_CYC     = DWELL_MS * CLK_FREQ_KHZ,
	parameter int unsigned DATA_FAIL_CYC = DATA_FAIL_MS * CLK_FREQ_KHZ,
	parameter int          CODE_W        = 16
) (
	input  wire logic                   sys_clk_in,
	input  wire logic                   reset_n_in,
	input  wire logic [N_LOCAL-1:0]     alarm_raw_in,
	input  wire logic [2*N_LOCAL-1:0]   cfg_class_in,
	input  wire logic                   estop_in,
	input  wire logic                   mute_in,
	input  wire logic                   alarm_reset_in,
	input  wire logic                   cfg_latch_warn_in,
	input  wire logic                   cfg_common_led_en_in,
	input  wire logic [1:0]             cfg_prot_dis_mode_in,
	input  wire logic                   prot_dis_sw_in,
	input  wire logic                   cfg_sw_warn_en_in,
	input  wire logic                   cfg_log_sd_in,
	input  wire logic                   cfg_can_mode_in,
	input  wire logic                   can_frame_in,
	input  wire logic                   ecu_warn_in,
	input  wire logic                   ecu_sd_in,
	input  wire logic [CODE_W-1:0]      ecu_err_code_in,
	input  wire logic [3:0]             lamp_in,
	input  wire logic [7:0]             cfg_lamp_action_in,
	input  wire logic [1:0]             adv_in,
	input  wire logic [3:0]             cfg_adv_action_in,
	output logic                        sounder_out,
	output logic                        common_led_out,
	output logic                        engine_stop_out,
	output logic                        load_open_out,
	output logic [N_LOCAL-1:0]          ind_led_out,
	output logic                        disp_page_out,
	output logic [$clog2(N_LOCAL+NUM_INT)-1:0] disp_idx_out,
	output logic [1:0]                  disp_cls_out,
	output logic [$clog2(N_LOCAL+NUM_INT):0]   disp_count_out,
	output logic                        disp_prot_dis_out,
	output logic                        disp_sd_blocked_out,
	output logic [CODE_W-1:0]           disp_ecu_code_out,
	output logic                        log_wr_out,
	output logic [$clog2(N_LOCAL+NUM_INT)-1:0] log_src_out,
	output logic                        log_blocked_out
);

	localparam int M  = N_LOCAL + NUM_INT;
	localparam int IW = $clog2(M);
	localparam int PW = IW + 1;

	// ----------------------------------------
	// source assembly
	// ----------------------------------------
	logic [NUM_INT-1:0]   cond_int;
	logic [2*NUM_INT-1:0] cls_int;
	logic [M-1:0]         cond_all;
	logic [2*M-1:0]       cls_all;
	logic [M-1:0]         active_vec;
	logic [M-1:0]         raised_vec;
	logic                 prot_dis;
	logic [31:0]          silence_q;
	logic                 data_fail;

	// (R7) override mode select
	assign prot_dis = (cfg_prot_dis_mode_in == PD_ALWAYS) ||
			((cfg_prot_dis_mode_in == PD_SWITCH) && prot_dis_sw_in);

	// (R14) link silence timer
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || !cfg_can_mode_in || can_frame_in) begin
			silence_q <= '0;
		end else if (silence_q != DATA_FAIL_CYC) begin
			silence_q <= silence_q + 32'h1;
		end
	end
	assign data_fail = cfg_can_mode_in && (silence_q == DATA_FAIL_CYC);

	always_comb begin
		cond_int = '0;
		cls_int  = '0;
		// (R10) estop fixed shutdown
		cond_int[INT_ESTOP]  = estop_in;
		cls_int[INT_ESTOP*CLS_W +: CLS_W] = CLS_SD;
		// (R8) override switch warning
		cond_int[INT_SWWARN] = prot_dis_sw_in && cfg_sw_warn_en_in &&
				(cfg_prot_dis_mode_in == PD_SWITCH);
		cls_int[INT_SWWARN*CLS_W +: CLS_W] = CLS_WARN;
		// (R14) data fail shutdown
		cond_int[INT_DFAIL]  = data_fail;
		cls_int[INT_DFAIL*CLS_W +: CLS_W] = CLS_SD;
		// (R15) controller warning
		cond_int[INT_ECUWARN] = ecu_warn_in;
		cls_int[INT_ECUWARN*CLS_W +: CLS_W] = CLS_WARN;
		// (R16) controller shutdown
		cond_int[INT_ECUSD]  = ecu_sd_in;
		cls_int[INT_ECUSD*CLS_W +: CLS_W] = CLS_SD;
		// (R17) lamp class actions
		cond_int[INT_AMBER]   = lamp_in[LAMP_AMBER];
		cls_int[INT_AMBER*CLS_W +: CLS_W] = cfg_lamp_action_in[LAMP_AMBER*CLS_W +: CLS_W];
		cond_int[INT_RED]     = lamp_in[LAMP_RED];
		cls_int[INT_RED*CLS_W +: CLS_W] = cfg_lamp_action_in[LAMP_RED*CLS_W +: CLS_W];
		cond_int[INT_MALF]    = lamp_in[LAMP_MALF];
		cls_int[INT_MALF*CLS_W +: CLS_W] = cfg_lamp_action_in[LAMP_MALF*CLS_W +: CLS_W];
		cond_int[INT_PROTECT] = lamp_in[LAMP_PROT];
		cls_int[INT_PROTECT*CLS_W +: CLS_W] = cfg_lamp_action_in[LAMP_PROT*CLS_W +: CLS_W];
		// (R18) advanced message actions
		cond_int[INT_WIF] = adv_in[ADV_WIF];
		cls_int[INT_WIF*CLS_W +: CLS_W] = cfg_adv_action_in[ADV_WIF*CLS_W +: CLS_W];
		cond_int[INT_AFT] = adv_in[ADV_AFT];
		cls_int[INT_AFT*CLS_W +: CLS_W] = cfg_adv_action_in[ADV_AFT*CLS_W +: CLS_W];
	end

	assign cond_all = {cond_int, alarm_raw_in};
	assign cls_all  = {cls_int, cfg_class_in};

	// (R20) per-source latching cells
	// (R9) cells ignore override
	for (genvar gi = 0; gi < M; gi++) begin : g_cell
		apm_alarm_cell u_cell (
			.sys_clk_in    (sys_clk_in),
			.reset_n_in    (reset_n_in),
			.cond_in       (cond_all[gi]),
			.class_in      (cls_all[gi*CLS_W +: CLS_W]),
			.latch_warn_in (cfg_latch_warn_in),
			.reset_req_in  (alarm_reset_in),
			.active_out    (active_vec[gi]),
			.raised_out    (raised_vec[gi])
		);
	end

	// ----------------------------------------
	// class summaries
	// ----------------------------------------
	logic             any_active;
	logic             any_raised;
	logic             sd_other;
	logic             trip_other;
	logic [IW:0]      act_cnt;

	always_comb begin
		sd_other   = 1'b0;
		trip_other = 1'b0;
		act_cnt    = '0;
		for (int i = 0; i < M; i++) begin
			act_cnt = act_cnt + {{IW{1'b0}}, active_vec[i]};
			if (active_vec[i] && (i != N_LOCAL + INT_ESTOP)) begin
				sd_other   = sd_other || (cls_all[i*CLS_W +: CLS_W] == CLS_SD);
				trip_other = trip_other || (cls_all[i*CLS_W +: CLS_W] == CLS_TRIP);
			end
		end
	end
	assign any_active = |active_vec;
	assign any_raised = |raised_vec;

	// ----------------------------------------
	// sounder, indicators and engine actions
	// ----------------------------------------
	logic mute_q;
	logic mute_d;
	logic estop_act;

	// (R2) mute held until a new raise or until no alarm is active
	always_comb begin
		mute_d = mute_q;
		if (any_raised || !any_active) begin
			mute_d = 1'b0;
		end else if (mute_in) begin
			mute_d = 1'b1;
		end
	end
	assign estop_act = active_vec[N_LOCAL + INT_ESTOP];

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			mute_q         <= 1'b0;
			sounder_out    <= 1'b0;
			common_led_out <= 1'b0;
		end else begin
			mute_q         <= mute_d;
			// (R1) sounder and common LED
			sounder_out    <= any_active && !mute_d;
			// (R21) mute leaves the LED alone
			common_led_out <= any_active && cfg_common_led_en_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			engine_stop_out     <= 1'b0;
			load_open_out       <= 1'b0;
			disp_prot_dis_out   <= 1'b0;
			disp_sd_blocked_out <= 1'b0;
		end else begin
			// (R11) override keeps engine and load switch
			engine_stop_out     <= estop_act || (sd_other && !prot_dis);
			load_open_out       <= estop_act || ((sd_other || trip_other) && !prot_dis);
			// (R6) override status shown
			disp_prot_dis_out   <= prot_dis;
			// (R12) shutdown blocked flag
			disp_sd_blocked_out <= prot_dis && (sd_other || trip_other);
		end
	end

	// (R19) indication inputs feed LEDs only
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			ind_led_out <= '0;
		end else begin
			for (int i = 0; i < N_LOCAL; i++) begin
				ind_led_out[i] <= alarm_raw_in[i] && (cfg_class_in[i*CLS_W +: CLS_W] == CLS_IND);
			end
		end
	end

	// (R15) latch controller error code
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			disp_ecu_code_out <= '0;
		end else if (ecu_warn_in || ecu_sd_in) begin
			disp_ecu_code_out <= ecu_err_code_in;
		end
	end

	// ----------------------------------------
	// occurrence order queue
	// ----------------------------------------
	logic [M-1:0]  pend_q;
	logic [M-1:0]  queued_q;
	logic [M-1:0]  cand;
	logic [IW-1:0] sel;
	logic          append;
	logic          pop;
	logic [PW-1:0] head_q;
	logic [PW-1:0] tail_q;
	logic [PW-1:0] head_nx;
	logic [IW-1:0] rd_data;
	logic [PW-1:0] scan_q;
	logic [PW-1:0] scan_nx;

	assign cand = pend_q & ~queued_q;
	always_comb begin
		sel = '0;
		for (int i = M - 1; i >= 0; i--) begin
			if (cand[i]) begin
				sel = IW'(i);
			end
		end
	end
	assign append = |cand;

	// (R4) raise order kept in memory
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			pend_q   <= '0;
			queued_q <= '0;
			tail_q   <= '0;
			head_q   <= '0;
		end else begin
			pend_q <= (pend_q & ~queued_q & ~(append ? (M'(1) << sel) : '0)) | raised_vec;
			if (append) begin
				tail_q <= tail_q + PW'(1);
			end
			head_q   <= head_nx;
			queued_q <= (queued_q | (append ? (M'(1) << sel) : '0)) &
					~(pop ? (M'(1) << rd_data) : '0);
		end
	end

	apm_order_mem #(
		.WIDTH (IW),
		.AW    (IW)
	) u_order (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (append),
		.wr_addr_in  (tail_q[IW-1:0]),
		.wr_data_in  (sel),
		.rd_addr_in  (scan_q[IW-1:0]),
		.rd_data_out (rd_data)
	);

	// ----------------------------------------
	// display scroll
	// ----------------------------------------
	apm_state_t  st_q;
	logic [31:0] dwell_q;
	logic        stale;

	assign stale   = (int'(rd_data) >= M) || !active_vec[rd_data];
	assign pop     = (st_q == APM_ST_CHECK) && (head_q != tail_q) && stale && (scan_q == head_q);
	assign head_nx = pop ? head_q + PW'(1) : head_q;
	assign scan_nx = ((scan_q + PW'(1)) == tail_q) ? head_nx : scan_q + PW'(1);

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			st_q         <= APM_ST_IDLE;
			scan_q       <= '0;
			dwell_q      <= '0;
			disp_idx_out <= '0;
			disp_cls_out <= CLS_IND;
		end else begin
			unique case (st_q)
				APM_ST_IDLE: begin
					if (head_q != tail_q) begin
						scan_q <= head_q;
						st_q   <= APM_ST_READ;
					end
				end
				APM_ST_READ: begin
					st_q <= APM_ST_CHECK;
				end
				APM_ST_CHECK: begin
					if (head_q == tail_q) begin
						st_q <= APM_ST_IDLE;
					end else if (stale) begin
						scan_q <= scan_nx;
						st_q   <= APM_ST_READ;
					end else begin
						// (R5) every active entry shown in turn
						disp_idx_out <= rd_data;
						disp_cls_out <= cls_all[rd_data*CLS_W +: CLS_W];
						dwell_q      <= '0;
						st_q         <= APM_ST_SHOW;
					end
				end
				APM_ST_SHOW: begin
					dwell_q <= dwell_q + 32'h1;
					// (R4) advance after dwell
					if ((dwell_q >= DWELL_CYC - 1) || !active_vec[disp_idx_out]) begin
						scan_q <= scan_nx;
						st_q   <= APM_ST_READ;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			disp_page_out  <= PAGE_INFO;
			disp_count_out <= '0;
		end else begin
			// (R3) alarm page while alarms active
			disp_page_out  <= any_active ? PAGE_ALARM : PAGE_INFO;
			disp_count_out <= act_cnt;
		end
	end

	// ----------------------------------------
	// event log
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			log_wr_out      <= 1'b0;
			log_src_out     <= '0;
			log_blocked_out <= 1'b0;
		end else begin
			// (R13) log with prevented note
			log_wr_out      <= append && cfg_log_sd_in && cls_all[sel*CLS_W + 1];
			log_src_out     <= sel;
			log_blocked_out <= prot_dis && (int'(sel) != N_LOCAL + INT_ESTOP);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_mute_quiet;
		mute_in && any_active && !any_raised ##1 !any_raised && active_vec != '0;
	endsequence

	a_sounder_on: assert property (any_active && !mute_d && $past(reset_n_in) |=> sounder_out) // R1
		else $error("sounder not driven for active alarm");
	a_mute_silent: assert property (s_mute_quiet |=> !sounder_out) // R2
		else $error("sounder still on after mute");
	a_alarm_page: assert property ($rose(any_active) |=> disp_page_out == PAGE_ALARM) // R3
		else $error("alarm page not shown");
	a_scroll_bound: assert property (st_q == APM_ST_SHOW |-> dwell_q < DWELL_CYC) // R4
		else $error("dwell overran");
	a_estop_stop: assert property (estop_in |=> ##1 engine_stop_out && load_open_out) // R10
		else $error("estop did not stop engine");
	a_prot_hold: assert property (prot_dis && !estop_act |=> !engine_stop_out && !load_open_out) // R11
		else $error("override failed to hold engine");
	a_blocked_flag: assert property (prot_dis && (sd_other || trip_other) |=> disp_sd_blocked_out) // R12
		else $error("shutdown blocked not shown");
	a_log_note: assert property (append && cfg_log_sd_in && cls_all[sel*CLS_W +: CLS_W] == CLS_SD && prot_dis && int'(sel) != N_LOCAL + INT_ESTOP |=> log_wr_out && log_blocked_out) // R13
		else $error("blocked shutdown not logged");
	a_data_fail: assert property (data_fail && !prot_dis |=> ##1 engine_stop_out) // R14
		else $error("data fail did not stop engine");
	a_ind_quiet: assert property ((ind_led_out & active_vec[N_LOCAL-1:0]) == '0) // R19
		else $error("indication raised an alarm");
	a_warn_clear: assert property (!cond_all[N_LOCAL+INT_SWWARN] && !cfg_latch_warn_in |=> !active_vec[N_LOCAL+INT_SWWARN]) // R20
		else $error("warning did not self clear");

endmodule : apm_alarm_manager

/* hw/apm_pkg.sv */
// Purpose: shared constants and types of the alarm protection manager
// Assumes: single 200 MHz clock, synchronous active-low reset
// Notes:   alarm class codes double as the action codes of engine lamp messages
package apm_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_FREQ_KHZ = 200000;
	localparam int unsigned DWELL_MS     = 2000;
	localparam int unsigned DATA_FAIL_MS = 3000;

	// ----------------------------------------
	// alarm classes and lamp actions
	// ----------------------------------------
	localparam int          CLS_W    = 2;
	localparam logic [1:0]  CLS_IND  = 2'h0;
	localparam logic [1:0]  CLS_WARN = 2'h1;
	localparam logic [1:0]  CLS_TRIP = 2'h2;
	localparam logic [1:0]  CLS_SD   = 2'h3;

	// ----------------------------------------
	// override modes and pages
	// ----------------------------------------
	localparam logic [1:0]  PD_OFF     = 2'h0;
	localparam logic [1:0]  PD_ALWAYS  = 2'h1;
	localparam logic [1:0]  PD_SWITCH  = 2'h2;
	localparam logic        PAGE_INFO  = 1'h0;
	localparam logic        PAGE_ALARM = 1'h1;

	// ----------------------------------------
	// internal alarm sources, placed above the local inputs
	// ----------------------------------------
	localparam int NUM_INT     = 11;
	localparam int INT_ESTOP   = 0;
	localparam int INT_SWWARN  = 1;
	localparam int INT_DFAIL   = 2;
	localparam int INT_ECUWARN = 3;
	localparam int INT_ECUSD   = 4;
	localparam int INT_AMBER   = 5;
	localparam int INT_RED     = 6;
	localparam int INT_MALF    = 7;
	localparam int INT_PROTECT = 8;
	localparam int INT_WIF     = 9;
	localparam int INT_AFT     = 10;
	localparam int LAMP_AMBER  = 0;
	localparam int LAMP_RED    = 1;
	localparam int LAMP_MALF   = 2;
	localparam int LAMP_PROT   = 3;
	localparam int ADV_WIF     = 0;
	localparam int ADV_AFT     = 1;

	typedef enum logic [1:0] {
		APM_ST_IDLE  = 2'b00,
		APM_ST_READ  = 2'b01,
		APM_ST_CHECK = 2'b10,
		APM_ST_SHOW  = 2'b11
	} apm_state_t;

endpackage : apm_pkg

/* hw/apm_alarm_cell.sv */
// Purpose: one alarm source: activation, latching and manual reset
// Assumes: cond_in synchronous to sys_clk_in
// Notes:   indication class never becomes an active alarm
`timescale 1ns/100ps
module apm_alarm_cell
	import apm_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       reset_n_in,
	input  wire logic       cond_in,
	input  wire logic [1:0] class_in,
	input  wire logic       latch_warn_in,
	input  wire logic       reset_req_in,
	output logic            active_out,
	output logic            raised_out
);

	logic active_q;
	logic active_d;

	always_comb begin
		active_d = active_q;
		if (class_in == CLS_IND) begin
			active_d = 1'b0;
		end else if (cond_in) begin
			active_d = 1'b1;
		end else if (reset_req_in) begin
			active_d = 1'b0;
		end else if ((class_in == CLS_WARN) && !latch_warn_in) begin
			active_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			active_q <= 1'b0;
		end else begin
			active_q <= active_d;
		end
	end

	assign active_out = active_q;
	assign raised_out = active_d && !active_q;

endmodule : apm_alarm_cell

/* hw/apm_order_mem.sv */
// Purpose: small memory holding alarm indices in order of raising
// Assumes: one write and one read port, same clock
// Notes:   read data is registered, one cycle after the address
`timescale 1ns/100ps
module apm_order_mem #(
	parameter int WIDTH = 5,
	parameter int AW    = 5
) (
	input  wire logic             sys_clk_in,
	input  wire logic             wr_en_in,
	input  wire logic [AW-1:0]    wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	logic [WIDTH-1:0] mem_q [0:(1<<AW)-1];
	logic [WIDTH-1:0] rd_data_q;

	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem_q[wr_addr_in] <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		rd_data_q <= mem_q[rd_addr_in];
	end

	assign rd_data_out = rd_data_q;

endmodule : apm_order_mem

/* verification/apm_ecu_model.sv */
// Purpose: engine controller stand-in for the alarm manager
// Assumes: same clock as the manager
// Notes:   code lines toggle while no alarm is reported
`timescale 1ns/100ps
module apm_ecu_model #(
	parameter int          GAP  = 10,
	parameter logic [15:0] CODE = 16'h5A3C
) (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        frames_en_in,
	input  wire logic        warn_req_in,
	input  wire logic        sd_req_in,
	input  wire logic [3:0]  lamp_req_in,
	output logic             can_frame_out,
	output logic             ecu_warn_out,
	output logic             ecu_sd_out,
	output logic [15:0]      code_out,
	output logic [3:0]       lamp_out
);
	int cnt_q;
	// ----------------------------------------
	// frame pacing, silent when disabled
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in || !frames_en_in) begin
			cnt_q         <= 0;
			can_frame_out <= 1'b0;
		end else begin
			cnt_q         <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
			can_frame_out <= (cnt_q == GAP - 1);
		end
	end
	// ----------------------------------------
	// alarm flags and error code
	// ----------------------------------------
	always_ff @(posedge sys_clk_in) begin
		ecu_warn_out <= warn_req_in;
		ecu_sd_out   <= sd_req_in;
		lamp_out     <= lamp_req_in;
		code_out     <= (warn_req_in || sd_req_in) ? CODE : ~code_out;
	end
endmodule : apm_ecu_model

/* verification/apm_alarm_manager_tb.sv */
// Purpose: self-checking bench of the alarm protection manager
// Assumes: dwell 20 and data-fail 50 cycles
// Notes:   engine controller side is apm_ecu_model
`timescale 1ns/100ps
module apm_alarm_manager_tb
	import apm_pkg::*;
;
	localparam logic [15:0] ECU_CODE = 16'h5A3C;
	logic sys_clk_in, reset_n_in, estop_in, mute_in, alarm_reset_in, cfg_latch_warn_in;
	logic cfg_common_led_en_in, prot_dis_sw_in, cfg_sw_warn_en_in, cfg_log_sd_in;
	logic cfg_can_mode_in, can_frame_in, ecu_warn_in, ecu_sd_in, frames_en, warn_req;
	logic sounder_out, common_led_out, engine_stop_out, load_open_out, disp_page_out;
	logic disp_prot_dis_out, disp_sd_blocked_out, log_wr_out, log_blocked_out;
	logic        sd_req, last_blk;
	logic [7:0]  alarm_raw_in, cfg_lamp_action_in, ind_led_out;
	logic [15:0] cfg_class_in, ecu_err_code_in, disp_ecu_code_out;
	logic [1:0]  cfg_prot_dis_mode_in, adv_in, disp_cls_out;
	logic [3:0]  lamp_in, cfg_adv_action_in, lamp_req;
	logic [4:0]  disp_idx_out, log_src_out, last_src;
	logic [5:0]  disp_count_out;
	int          n_errors, total_checks, cyc_cnt;

	apm_alarm_manager #(.N_LOCAL(8), .DWELL_CYC(20), .DATA_FAIL_CYC(50), .CODE_W(16)) dut (
		.sys_clk_in, .reset_n_in, .alarm_raw_in, .cfg_class_in, .estop_in, .mute_in,
		.alarm_reset_in, .cfg_latch_warn_in, .cfg_common_led_en_in, .cfg_prot_dis_mode_in,
		.prot_dis_sw_in, .cfg_sw_warn_en_in, .cfg_log_sd_in, .cfg_can_mode_in, .can_frame_in,
		.ecu_warn_in, .ecu_sd_in, .ecu_err_code_in, .lamp_in, .cfg_lamp_action_in, .adv_in,
		.cfg_adv_action_in, .sounder_out, .common_led_out, .engine_stop_out, .load_open_out,
		.ind_led_out, .disp_page_out, .disp_idx_out, .disp_cls_out, .disp_count_out,
		.disp_prot_dis_out, .disp_sd_blocked_out, .disp_ecu_code_out, .log_wr_out,
		.log_src_out, .log_blocked_out);

	apm_ecu_model #(.GAP(10), .CODE(ECU_CODE)) ecu (
		.sys_clk_in, .reset_n_in, .frames_en_in(frames_en), .warn_req_in(warn_req),
		.sd_req_in(sd_req), .lamp_req_in(lamp_req), .can_frame_out(can_frame_in),
		.ecu_warn_out(ecu_warn_in), .ecu_sd_out(ecu_sd_in), .code_out(ecu_err_code_in),
		.lamp_out(lamp_in));

	// ----------------------------------------
	// clock, timeout, log capture
	// ----------------------------------------
	initial begin
		sys_clk_in = 1'b0;
		forever #2.5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cyc_cnt++;
		if (cyc_cnt == 2000) begin
			n_errors++;
			give_verdict();
		end
		if (log_wr_out === 1'b1) begin
			last_src <= log_src_out;
			last_blk <= log_blocked_out;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	task automatic wn(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : wn
	task automatic clr;
		@(posedge sys_clk_in) alarm_reset_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		alarm_reset_in <= 1'b0;
		wn(4);
	endtask : clr
	task automatic give_verdict;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{estop_in, mute_in, alarm_reset_in, cfg_latch_warn_in, prot_dis_sw_in} = '0;
		{cfg_sw_warn_en_in, cfg_can_mode_in, frames_en, warn_req, sd_req} = '0;
		{cfg_common_led_en_in, cfg_log_sd_in} = 2'h3;
		{alarm_raw_in, lamp_req, adv_in, cfg_lamp_action_in, cfg_adv_action_in} = '0;
		cfg_prot_dis_mode_in = PD_OFF;
		cfg_class_in = {CLS_IND, CLS_IND, CLS_IND, CLS_TRIP, CLS_SD, CLS_WARN, CLS_SD, CLS_WARN};
		reset_n_in = 1'b0;
		repeat (8) @(posedge sys_clk_in);
		reset_n_in <= 1'b1;
		wn(1);
		chk(sounder_out, 1'b0);
		chk(disp_page_out, PAGE_INFO);
		// warning: sound, led, page, mute, self-clear, latch
		@(posedge sys_clk_in) alarm_raw_in <= 8'h01;
		wn(4);
		chk(sounder_out, 1'b1);
		chk(common_led_out, 1'b1);
		chk(disp_page_out, PAGE_ALARM);
		@(posedge sys_clk_in) mute_in <= 1'b1;
		@(posedge sys_clk_in) mute_in <= 1'b0;
		wn(3);
		chk(sounder_out, 1'b0);
		chk(common_led_out, 1'b1);
		chk(disp_count_out, 6'h01);
		@(posedge sys_clk_in) alarm_raw_in <= 8'h00;
		wn(4);
		chk(disp_count_out, 6'h00);
		@(posedge sys_clk_in) cfg_latch_warn_in <= 1'b1;
		alarm_raw_in <= 8'h01;
		@(posedge sys_clk_in) alarm_raw_in <= 8'h00;
		wn(4);
		chk(disp_count_out, 6'h01);
		clr();
		chk(disp_count_out, 6'h00);
		// warning then shutdown, scroll order
		@(posedge sys_clk_in) alarm_raw_in <= 8'h04;
		cfg_latch_warn_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		alarm_raw_in <= 8'h0C;
		wn(8);
		chk(disp_count_out, 6'h02);
		chk(disp_idx_out, 5'h02);
		chk(disp_cls_out, CLS_WARN);
		chk(engine_stop_out, 1'b1);
		chk(load_open_out, 1'b1);
		chk({last_blk, last_src}, 6'h03);
		wn(20);
		chk(disp_idx_out, 5'h03);
		chk(disp_cls_out, CLS_SD);
		@(posedge sys_clk_in) alarm_raw_in <= 8'h00;
		clr();
		// switch-controlled and always-on override, indication LED
		@(posedge sys_clk_in) cfg_prot_dis_mode_in <= PD_SWITCH;
		cfg_sw_warn_en_in <= 1'b1;
		wn(4);
		chk(disp_prot_dis_out, 1'b0);
		@(posedge sys_clk_in) prot_dis_sw_in <= 1'b1;
		wn(4);
		chk(disp_prot_dis_out, 1'b1);
		chk(disp_count_out, 6'h01);
		@(posedge sys_clk_in) alarm_raw_in <= 8'h18;
		wn(8);
		chk({engine_stop_out, load_open_out}, 2'h0);
		chk(disp_sd_blocked_out, 1'b1);
		chk(disp_count_out, 6'h03);
		chk({last_blk, last_src}, 6'h24);
		@(posedge sys_clk_in) estop_in <= 1'b1;
		wn(4);
		chk(engine_stop_out, 1'b1);
		@(posedge sys_clk_in) {estop_in, prot_dis_sw_in, alarm_raw_in} <= '0;
		cfg_prot_dis_mode_in <= PD_ALWAYS;
		clr();
		chk(disp_prot_dis_out, 1'b1);
		@(posedge sys_clk_in) alarm_raw_in <= 8'h01;
		wn(4);
		chk({sounder_out, disp_count_out}, 7'h41);
		@(posedge sys_clk_in) alarm_raw_in <= 8'h20;
		cfg_prot_dis_mode_in <= PD_OFF;
		wn(4);
		chk(ind_led_out, 8'h20);
		chk({sounder_out, disp_count_out}, 7'h00);
		// engine controller warning, shutdown, lamps, advanced
		@(posedge sys_clk_in) alarm_raw_in <= 8'h00;
		warn_req <= 1'b1;
		wn(6);
		chk({engine_stop_out, disp_ecu_code_out}, {1'b0, ECU_CODE});
		@(posedge sys_clk_in) {warn_req, sd_req} <= 2'h1;
		wn(6);
		chk({engine_stop_out, disp_ecu_code_out}, {1'b1, ECU_CODE});
		@(posedge sys_clk_in) sd_req <= 1'b0;
		clr();
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk_in) cfg_lamp_action_in <= 8'(CLS_SD) << (2 * i);
			lamp_req <= 4'(1) << i;
			wn(6);
			chk(engine_stop_out, 1'b1);
			@(posedge sys_clk_in) lamp_req <= 4'h0;
			clr();
		end
		@(posedge sys_clk_in) cfg_lamp_action_in <= 8'h00;
		lamp_req <= 4'hF;
		wn(6);
		chk(disp_count_out, 6'h00);
		@(posedge sys_clk_in) lamp_req <= 4'h0;
		cfg_adv_action_in <= {CLS_WARN, CLS_TRIP};
		adv_in <= 2'h3;
		wn(6);
		chk({load_open_out, disp_count_out}, 7'h42);
		@(posedge sys_clk_in) adv_in <= 2'h0;
		clr();
		// engine link data fail
		@(posedge sys_clk_in) {cfg_can_mode_in, frames_en} <= 2'h3;
		wn(80);
		chk(disp_count_out, 6'h00);
		@(posedge sys_clk_in) frames_en <= 1'b0;
		wn(70);
		chk(engine_stop_out, 1'b1);
		give_verdict();
	end
endmodule : apm_alarm_manager_tb
